// ### pmr_map.vh
`ifndef PMR_MAP_VH
`define PMR_MAP_VH

// Register indexes.
`define PMR_REG_EXPANSION 5'h06
`define PMR_REG_NP_TX 5'h07
`define PMR_REG_NP_RX 5'h08
`define PMR_REG_MS_CTRL 5'h09
`define PMR_REG_MS_STAT 5'h0a
`define PMR_REG_IND_CTRL 5'h0d
`define PMR_REG_IND_DATA 5'h0e
`define PMR_REG_EXT_STAT 5'h0f
`define PMR_REG_FAR_LOOP 5'h11
`define PMR_REG_CABLE 5'h12

// Management frame fields.
`define PMR_OP_READ 2'h2
`define PMR_OP_WRITE 2'h1
`define PMR_HDR_LAST 5'h0b
`define PMR_TA_LAST 5'h01
`define PMR_DATA_LAST 5'h0f
`define PMR_PHY_ADDR_DEF 5'h01

// Expansion register bit positions.
`define PMR_EXP_PDF 4
`define PMR_EXP_PAGE_RX 1

// Next-page transmit reset values.
`define PMR_NPTX_MP_RST 1'h1
`define PMR_NPTX_MSG_RST 11'h001

// Master/slave control reset values and test modes.
`define PMR_ADV_FD_RST 1'h1
`define PMR_TM_NORMAL 3'h0
`define PMR_TM_LAST 3'h4
`define PMR_IDLE_MAX 8'hff

// Indirect access functions.
`define PMR_FN_ADDR 2'h0
`define PMR_FN_DATA 2'h1
`define PMR_FN_INC_RW 2'h2
`define PMR_FN_INC_W 2'h3

// Cable test views, outcomes and thresholds.
`define PMR_VIEW_RESULT 2'h0
`define PMR_VIEW_HIGH 2'h1
`define PMR_VIEW_LOW 2'h2
`define PMR_OUT_FAILED 2'h3
`define PMR_THR_HIGH 10'h040
`define PMR_THR_LOW 10'h3c0
`define PMR_PULSE_MAX 2'h3

`endif

// ### pmr_mdio_station.sv
`timescale 1ns/1ps
module pmr_mdio_station (
  input wire clk,
  input wire dev_out,
  input wire dev_oe,
  output logic mdc,
  output wire line
);
  logic st_oe;
  logic st_out;
  logic [4:0] phy;
  // The line has a pull-up, so a released line reads 1 and never repeats stale data.
  assign line = dev_oe ? dev_out : (st_oe ? st_out : 1'b1);
  initial begin
    mdc = 1'b0;
    st_oe = 1'b0;
    st_out = 1'b1;
    phy = 5'h01;
  end
  // One bit spans eight system clocks, leaving room for the device's input synchronisers.
  task automatic bit_cyc(input logic oe, input logic v, output logic s);
    st_oe = oe;
    st_out = v;
    repeat (4) @(posedge clk);
    #1 mdc = 1'b1;
    s = line;
    repeat (4) @(posedge clk);
    #1 mdc = 1'b0;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic drv;
    hdr = {2'b01, op, phy, ra};
    drv = (op != 2'h2);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    bit_cyc(drv, 1'b1, s);
    bit_cyc(drv, 1'b0, s);
    for (int i = 15; i >= 0; i--) bit_cyc(drv, wd[i], rd[i]);
    st_oe = 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask
endmodule // pmr_mdio_station

// ### pmr_mgmt_regs.v
// Operation
// - Expansion bits 4 and 1 latch high on their event until the register is read.
// - Expansion bits 6, 5, 2 read 1; bits 3 and 0 show partner abilities.
// - Next-page transmit word: writable NP, MP, ACK2, code; read-only toggle flips per page.
// - Next-page receive register holds the partner's last next page, resetting to zero.
// - Test-mode field 15:13 selects transmitter test; codes 101 to 111 reserved.
// - Manual master/slave value applies only while manual enable bit 12 is set.
// - Control bit 10 declares single-port (0) or multi-port (1); default 0.
// - Gigabit full duplex advertised by bit 9, default 1; software writes bit 8 as 0.
// - Master/slave status bit 15 latches a configuration fault until read.
// - Status shows resolved role, local and remote receiver OK, partner gigabit abilities.
// - Idle error counter in bits 7:0 saturates at 0xFF and clears on read.
// - Indirect control holds function in 15:14 and device address in 4:0.
// - Function 00 makes the portal set the address; others move data there.
// - Extended status reads gigabit copper full duplex 1, other abilities 0.
// - Far-end loopback bit 8 enables or disables remote loopback; default 0.
// - Writing 1 to bit 15 starts cable test, self-clears on completion; 0 stops.
// - Bit 14 disables transmitter and holds cable test; clear lets test run.
// - Pair-select field 13:12 chooses pair A, B, C or D.
// - Selector 11:10 shows result, high threshold 64, low threshold -64; 11 reserved.
// - With selector 00, bits 9:8 give normal, open, short or failed outcome.
// - Failed test sets width, wait, high-frequency, fast flags and saturating pulse counts.
`timescale 1ns/1ps
`include "pmr_map.vh"

module pmr_mgmt_regs #(
  parameter [4:0] PHY_ADDRESS = `PMR_PHY_ADDR_DEF
) (
  input wire SYS_CLK,
  input wire RESETN,
  input wire MDC,
  input wire MDIO_IN,
  output wire MDIO_OUT,
  output wire MDIO_OE,
  input wire PAR_DET_FAULT,
  input wire PARTNER_NP_ABLE,
  input wire PARTNER_AN_ABLE,
  input wire RX_PAGE_VALID,
  input wire [15:0] RX_PAGE_WORD,
  input wire NP_TX_SENT,
  output wire [15:0] NP_TX_WORD,
  output wire [2:0] TEST_MODE,
  output wire MS_MANUAL_EN,
  output wire MS_MANUAL_MASTER,
  output wire MULTI_PORT,
  output wire ADV_1000FD,
  output wire ADV_1000HD,
  input wire MS_CONFIG_FAULT,
  input wire MS_RESOLVED_MASTER,
  input wire LOCAL_RX_OK,
  input wire REMOTE_RX_OK,
  input wire PARTNER_1000FD,
  input wire PARTNER_1000HD,
  input wire IDLE_ERROR,
  output wire [4:0] INDIRECT_DEVICE_SELECT,
  output wire [15:0] INDIRECT_ADDR,
  output wire [15:0] INDIRECT_WDATA,
  output wire INDIRECT_WR,
  output wire INDIRECT_RD,
  input wire [15:0] INDIRECT_RDATA,
  output wire REMOTE_LOOPBACK,
  output wire CABLE_TEST_RUN,
  output wire CABLE_TEST_TX_DISABLE,
  output wire [1:0] CABLE_TEST_PAIR_SELECT,
  output wire [9:0] CABLE_HIGH_THRESHOLD,
  output wire [9:0] CABLE_LOW_THRESHOLD,
  input wire CABLE_TEST_DONE,
  input wire [1:0] CABLE_TEST_OUTCOME,
  input wire [7:0] CABLE_TEST_VALUE,
  input wire [3:0] CABLE_FAIL_FLAGS,
  input wire CABLE_LOW_PULSE,
  input wire CABLE_HIGH_PULSE
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_HDR = 4'h2;
  localparam [3:0] ST_TA = 4'h4;
  localparam [3:0] ST_DATA = 4'h8;

  function [1:0] sat_inc2;
    input [1:0] v;
    begin
      sat_inc2 = (v == `PMR_PULSE_MAX) ? v : v + 2'h1;
    end
  endfunction

  // Pin synchronisers: a change counts once the second and third stages agree.
  reg mdc_s1_r, mdc_s2_r, mdc_s3_r, mdc_f_r;
  reg mdio_s1_r, mdio_s2_r, mdio_s3_r, mdio_f_r;
  wire mdc_rise;

  // Frame engine.
  reg [3:0] state_r;
  reg [4:0] cnt_r;
  reg [15:0] shift_r;
  reg prev_bit_r;
  reg is_read_r;
  reg sel_r;
  reg [4:0] reg_addr_r;
  reg mdio_out_r;
  reg mdio_oe_r;
  wire [11:0] hdr;
  wire rd_take;
  wire wr_take;
  wire [15:0] wr_data;
  reg [15:0] rd_word;

  // Register state.
  reg exp_pdf_r, exp_pgrx_r;
  reg np_next_r, np_mp_r, np_ack2_r, np_toggle_r;
  reg [10:0] np_msg_r;
  reg [15:0] rx_page_r;
  reg [2:0] ms_test_r;
  reg ms_man_en_r, ms_man_val_r, ms_multi_r, ms_adv_fd_r, ms_adv_hd_r;
  reg ms_fault_r;
  reg [7:0] idle_cnt_r;
  reg [1:0] ind_fn_r;
  reg [4:0] ind_dev_r;
  reg [15:0] ind_addr_r;
  reg [15:0] ind_wdata_r;
  reg ind_wr_r;
  reg far_loop_r;
  reg ct_en_r, ct_txdis_r;
  reg [1:0] ct_pair_r, ct_view_r, ct_outcome_r;
  reg [7:0] ct_value_r;
  reg [1:0] ct_lo_cnt_r, ct_hi_cnt_r;
  wire ct_run;
  wire ind_data_mode;
  wire ind_rd;
  wire wr_ind;

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mdc_s1_r <= 1'h0;
      mdc_s2_r <= 1'h0;
      mdc_s3_r <= 1'h0;
      mdc_f_r <= 1'h0;
      mdio_s1_r <= 1'h1;
      mdio_s2_r <= 1'h1;
      mdio_s3_r <= 1'h1;
      mdio_f_r <= 1'h1;
    end else begin
      mdc_s1_r <= MDC;
      mdc_s2_r <= mdc_s1_r;
      mdc_s3_r <= mdc_s2_r;
      mdio_s1_r <= MDIO_IN;
      mdio_s2_r <= mdio_s1_r;
      mdio_s3_r <= mdio_s2_r;
      if (mdc_s2_r == mdc_s3_r) begin
        mdc_f_r <= mdc_s3_r;
      end
      if (mdio_s2_r == mdio_s3_r) begin
        mdio_f_r <= mdio_s3_r;
      end
    end
  end

  assign mdc_rise = (mdc_s2_r == mdc_s3_r) && mdc_s3_r && !mdc_f_r;
  assign hdr = {shift_r[10:0], mdio_f_r};
  assign wr_data = {shift_r[14:0], mdio_f_r};
  // The snapshot and the clear-on-read effects share one edge, so an event landing in that
  // cycle survives to the next read instead of vanishing between snapshot and clear.
  assign rd_take = mdc_rise && (state_r == ST_TA) && (cnt_r == 5'h00) && is_read_r && sel_r;
  assign wr_take = mdc_rise && (state_r == ST_DATA) && (cnt_r == `PMR_DATA_LAST) && !is_read_r && sel_r;
  assign ind_data_mode = (ind_fn_r != `PMR_FN_ADDR);
  assign ind_rd = rd_take && (reg_addr_r == `PMR_REG_IND_DATA) && ind_data_mode;
  assign wr_ind = wr_take && (reg_addr_r == `PMR_REG_IND_DATA);

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      prev_bit_r <= 1'h1;
      is_read_r <= 1'h0;
      sel_r <= 1'h0;
      reg_addr_r <= 5'h00;
      mdio_out_r <= 1'h0;
      mdio_oe_r <= 1'h0;
    end else if (mdc_rise) begin
      case (state_r)
        ST_IDLE: begin
          prev_bit_r <= mdio_f_r;
          cnt_r <= 5'h00;
          // Preamble is optional; a 0 followed by a 1 on the idle-high line is the start.
          if (!prev_bit_r && mdio_f_r) begin
            state_r <= ST_HDR;
          end
        end
        ST_HDR: begin
          shift_r <= {shift_r[14:0], mdio_f_r};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `PMR_HDR_LAST) begin
            cnt_r <= 5'h00;
            reg_addr_r <= hdr[4:0];
            is_read_r <= (hdr[11:10] == `PMR_OP_READ);
            sel_r <= (hdr[9:5] == PHY_ADDRESS);
            if ((hdr[11:10] == `PMR_OP_READ) || (hdr[11:10] == `PMR_OP_WRITE)) begin
              state_r <= ST_TA;
            end else begin
              state_r <= ST_IDLE;
              prev_bit_r <= 1'h1;
            end
          end
        end
        ST_TA: begin
          cnt_r <= cnt_r + 5'h01;
          if (is_read_r && sel_r) begin
            if (cnt_r == 5'h00) begin
              mdio_oe_r <= 1'h1;
              mdio_out_r <= 1'h0;
              shift_r <= rd_word;
            end else begin
              mdio_out_r <= shift_r[15];
              shift_r <= {shift_r[14:0], 1'h0};
            end
          end
          if (cnt_r == `PMR_TA_LAST) begin
            cnt_r <= 5'h00;
            state_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          cnt_r <= cnt_r + 5'h01;
          if (is_read_r) begin
            mdio_out_r <= shift_r[15];
            shift_r <= {shift_r[14:0], 1'h0};
          end else begin
            shift_r <= wr_data;
          end
          if (cnt_r == `PMR_DATA_LAST) begin
            cnt_r <= 5'h00;
            mdio_oe_r <= 1'h0;
            mdio_out_r <= 1'h0;
            prev_bit_r <= 1'h1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          mdio_oe_r <= 1'h0;
          prev_bit_r <= 1'h1;
        end
      endcase
    end
  end

  always @* begin
    rd_word = 16'h0000;
    case (reg_addr_r)
      `PMR_REG_EXPANSION: begin
        rd_word[6] = 1'h1;
        rd_word[5] = 1'h1;
        rd_word[`PMR_EXP_PDF] = exp_pdf_r;
        rd_word[3] = PARTNER_NP_ABLE;
        rd_word[2] = 1'h1;
        rd_word[`PMR_EXP_PAGE_RX] = exp_pgrx_r;
        rd_word[0] = PARTNER_AN_ABLE;
      end
      `PMR_REG_NP_TX: rd_word = {np_next_r, 1'h0, np_mp_r, np_ack2_r, np_toggle_r, np_msg_r};
      `PMR_REG_NP_RX: rd_word = rx_page_r;
      `PMR_REG_MS_CTRL: rd_word = {ms_test_r, ms_man_en_r, ms_man_val_r, ms_multi_r, ms_adv_fd_r, ms_adv_hd_r,
                                   8'h00};
      `PMR_REG_MS_STAT: rd_word = {ms_fault_r, MS_RESOLVED_MASTER, LOCAL_RX_OK, REMOTE_RX_OK,
                                   PARTNER_1000FD, PARTNER_1000HD, 2'h0, idle_cnt_r};
      `PMR_REG_IND_CTRL: rd_word = {ind_fn_r, 9'h000, ind_dev_r};
      `PMR_REG_IND_DATA: rd_word = ind_data_mode ? INDIRECT_RDATA : ind_addr_r;
      `PMR_REG_EXT_STAT: rd_word[13] = 1'h1;
      `PMR_REG_FAR_LOOP: rd_word[8] = far_loop_r;
      `PMR_REG_CABLE: begin
        rd_word[15:10] = {ct_en_r, ct_txdis_r, ct_pair_r, ct_view_r};
        case (ct_view_r)
          `PMR_VIEW_RESULT: rd_word[9:0] = {ct_outcome_r, ct_value_r};
          `PMR_VIEW_HIGH: rd_word[9:0] = `PMR_THR_HIGH;
          `PMR_VIEW_LOW: rd_word[9:0] = `PMR_THR_LOW;
          default: rd_word[9:0] = 10'h000;
        endcase
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // Latched and counting status; a new event in the clearing cycle wins over the clear.
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      exp_pdf_r <= 1'h0;
      exp_pgrx_r <= 1'h0;
      rx_page_r <= 16'h0000;
      np_toggle_r <= 1'h0;
      ms_fault_r <= 1'h0;
      idle_cnt_r <= 8'h00;
    end else begin
      exp_pdf_r <= PAR_DET_FAULT | (exp_pdf_r & !(rd_take && reg_addr_r == `PMR_REG_EXPANSION));
      exp_pgrx_r <= RX_PAGE_VALID | (exp_pgrx_r & !(rd_take && reg_addr_r == `PMR_REG_EXPANSION));
      if (RX_PAGE_VALID) begin
        rx_page_r <= RX_PAGE_WORD;
      end
      if (NP_TX_SENT) begin
        np_toggle_r <= !np_toggle_r;
      end
      ms_fault_r <= MS_CONFIG_FAULT | (ms_fault_r & !(rd_take && reg_addr_r == `PMR_REG_MS_STAT));
      if (rd_take && reg_addr_r == `PMR_REG_MS_STAT) begin
        idle_cnt_r <= IDLE_ERROR ? 8'h01 : 8'h00;
      end else if (IDLE_ERROR && idle_cnt_r != `PMR_IDLE_MAX) begin
        idle_cnt_r <= idle_cnt_r + 8'h01;
      end
    end
  end

  // Software-written control.
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      np_next_r <= 1'h0;
      np_mp_r <= `PMR_NPTX_MP_RST;
      np_ack2_r <= 1'h0;
      np_msg_r <= `PMR_NPTX_MSG_RST;
      ms_test_r <= `PMR_TM_NORMAL;
      ms_man_en_r <= 1'h0;
      ms_man_val_r <= 1'h0;
      ms_multi_r <= 1'h0;
      ms_adv_fd_r <= `PMR_ADV_FD_RST;
      ms_adv_hd_r <= 1'h0;
      ind_fn_r <= `PMR_FN_ADDR;
      ind_dev_r <= 5'h00;
      far_loop_r <= 1'h0;
    end else if (wr_take) begin
      case (reg_addr_r)
        `PMR_REG_NP_TX: begin
          np_next_r <= wr_data[15];
          np_mp_r <= wr_data[13];
          np_ack2_r <= wr_data[12];
          np_msg_r <= wr_data[10:0];
        end
        `PMR_REG_MS_CTRL: begin
          ms_test_r <= wr_data[15:13];
          ms_man_en_r <= wr_data[12];
          ms_man_val_r <= wr_data[11];
          ms_multi_r <= wr_data[10];
          ms_adv_fd_r <= wr_data[9];
          ms_adv_hd_r <= wr_data[8];
        end
        `PMR_REG_IND_CTRL: begin
          ind_fn_r <= wr_data[15:14];
          ind_dev_r <= wr_data[4:0];
        end
        `PMR_REG_FAR_LOOP: far_loop_r <= wr_data[8];
        default: far_loop_r <= far_loop_r;
      endcase
    end
  end

  // Indirect portal: the write strobe is registered, so the pointer moves one cycle later
  // and the address seen with the strobe is still the one being written.
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ind_addr_r <= 16'h0000;
      ind_wdata_r <= 16'h0000;
      ind_wr_r <= 1'h0;
    end else begin
      ind_wr_r <= wr_ind && ind_data_mode;
      if (wr_ind) begin
        ind_wdata_r <= wr_data;
      end
      if (wr_ind && !ind_data_mode) begin
        ind_addr_r <= wr_data;
      end else if (ind_wr_r && (ind_fn_r == `PMR_FN_INC_RW || ind_fn_r == `PMR_FN_INC_W)) begin
        ind_addr_r <= ind_addr_r + 16'h0001;
      end else if (ind_rd && ind_fn_r == `PMR_FN_INC_RW) begin
        ind_addr_r <= ind_addr_r + 16'h0001;
      end
    end
  end

  // Cable test sequencing.
  assign ct_run = ct_en_r && !ct_txdis_r;

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ct_en_r <= 1'h0;
      ct_txdis_r <= 1'h0;
      ct_pair_r <= 2'h0;
      ct_view_r <= `PMR_VIEW_RESULT;
      ct_outcome_r <= 2'h0;
      ct_value_r <= 8'h00;
      ct_lo_cnt_r <= 2'h0;
      ct_hi_cnt_r <= 2'h0;
    end else begin
      if (wr_take && reg_addr_r == `PMR_REG_CABLE) begin
        // A write in the completion cycle wins, so a restart is never swallowed.
        ct_en_r <= wr_data[15];
        ct_txdis_r <= wr_data[14];
        ct_pair_r <= wr_data[13:12];
        ct_view_r <= wr_data[11:10];
        if (wr_data[15] && !ct_en_r) begin
          ct_lo_cnt_r <= 2'h0;
          ct_hi_cnt_r <= 2'h0;
        end
      end else if (ct_run && CABLE_TEST_DONE) begin
        ct_en_r <= 1'h0;
        ct_outcome_r <= CABLE_TEST_OUTCOME;
        if (CABLE_TEST_OUTCOME == `PMR_OUT_FAILED) begin
          ct_value_r <= {CABLE_FAIL_FLAGS, ct_lo_cnt_r, ct_hi_cnt_r};
        end else begin
          ct_value_r <= CABLE_TEST_VALUE;
        end
      end else if (ct_run) begin
        if (CABLE_LOW_PULSE) begin
          ct_lo_cnt_r <= sat_inc2(ct_lo_cnt_r);
        end
        if (CABLE_HIGH_PULSE) begin
          ct_hi_cnt_r <= sat_inc2(ct_hi_cnt_r);
        end
      end
    end
  end

  assign MDIO_OUT = mdio_out_r;
  assign MDIO_OE = mdio_oe_r;
  assign NP_TX_WORD = {np_next_r, 1'h0, np_mp_r, np_ack2_r, np_toggle_r, np_msg_r};
  // Reserved test codes fall back to normal transmission rather than an undefined pattern.
  assign TEST_MODE = (ms_test_r > `PMR_TM_LAST) ? `PMR_TM_NORMAL : ms_test_r;
  assign MS_MANUAL_EN = ms_man_en_r;
  assign MS_MANUAL_MASTER = ms_man_en_r & ms_man_val_r;
  assign MULTI_PORT = ms_multi_r;
  assign ADV_1000FD = ms_adv_fd_r;
  assign ADV_1000HD = ms_adv_hd_r;
  assign INDIRECT_DEVICE_SELECT = ind_dev_r;
  assign INDIRECT_ADDR = ind_addr_r;
  assign INDIRECT_WDATA = ind_wdata_r;
  assign INDIRECT_WR = ind_wr_r;
  assign INDIRECT_RD = ind_rd;
  assign REMOTE_LOOPBACK = far_loop_r;
  assign CABLE_TEST_RUN = ct_run;
  assign CABLE_TEST_TX_DISABLE = ct_txdis_r;
  assign CABLE_TEST_PAIR_SELECT = ct_pair_r;
  assign CABLE_HIGH_THRESHOLD = `PMR_THR_HIGH;
  assign CABLE_LOW_THRESHOLD = `PMR_THR_LOW;

endmodule // pmr_mgmt_regs

// ### pmr_mgmt_regs_assertions.sv
`timescale 1ns/1ps
module pmr_mgmt_regs_chk (
  input logic SYS_CLK,
  input logic RESETN,
  input logic NP_TX_SENT,
  input logic [15:0] NP_TX_WORD,
  input logic [2:0] TEST_MODE,
  input logic MS_MANUAL_EN,
  input logic MS_MANUAL_MASTER,
  input logic [15:0] INDIRECT_ADDR,
  input logic INDIRECT_WR,
  input logic INDIRECT_RD,
  input logic CABLE_TEST_RUN,
  input logic CABLE_TEST_TX_DISABLE,
  input logic CABLE_TEST_DONE,
  input logic [9:0] CABLE_HIGH_THRESHOLD,
  input logic [9:0] CABLE_LOW_THRESHOLD
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_test_done;
    CABLE_TEST_RUN && CABLE_TEST_DONE;
  endsequence
  sequence s_test_idle;
    !CABLE_TEST_RUN [*2];
  endsequence
  // A pointer move right after a strobe can only be the post-increment, never a reload.
  sequence s_strobe_then_move;
    (INDIRECT_WR || INDIRECT_RD) ##1 $changed(INDIRECT_ADDR);
  endsequence
  a_run_needs_tx: assert property (CABLE_TEST_RUN |-> !CABLE_TEST_TX_DISABLE)
    else $error("cable test runs with transmitter disabled");
  a_run_stops_done: assert property (s_test_done |=> s_test_idle)
    else $error("cable test still running after completion");
  a_thresh_fixed: assert property (CABLE_HIGH_THRESHOLD == 10'h040 && CABLE_LOW_THRESHOLD == 10'h3c0)
    else $error("pulse thresholds wrong");
  a_mode_legal: assert property (TEST_MODE <= 3'h4)
    else $error("reserved test mode driven");
  a_manual_gated: assert property (MS_MANUAL_MASTER |-> MS_MANUAL_EN)
    else $error("manual master without manual enable");
  a_toggle_flips: assert property (NP_TX_SENT |=> NP_TX_WORD[11] != $past(NP_TX_WORD[11]))
    else $error("toggle did not flip after a sent page");
  a_np_bit14_zero: assert property (NP_TX_WORD[14] == 1'b0)
    else $error("reserved next page bit set");
  a_wr_strobe_once: assert property (INDIRECT_WR |=> !INDIRECT_WR && !INDIRECT_RD)
    else $error("indirect write strobe too long");
  a_rd_strobe_once: assert property (INDIRECT_RD |-> !INDIRECT_WR ##1 !INDIRECT_RD)
    else $error("indirect read strobe too long");
  a_addr_held_strobe: assert property ((INDIRECT_WR || INDIRECT_RD) |-> $stable(INDIRECT_ADDR))
    else $error("indirect pointer moved during access");
  a_addr_step_one: assert property (s_strobe_then_move |-> INDIRECT_ADDR == $past(INDIRECT_ADDR) + 16'h1)
    else $error("indirect pointer did not step by one");
endmodule // pmr_mgmt_regs_chk

bind pmr_mgmt_regs pmr_mgmt_regs_chk u_pmr_mgmt_regs_chk (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .NP_TX_SENT(NP_TX_SENT), .NP_TX_WORD(NP_TX_WORD),
  .TEST_MODE(TEST_MODE), .MS_MANUAL_EN(MS_MANUAL_EN), .MS_MANUAL_MASTER(MS_MANUAL_MASTER),
  .INDIRECT_ADDR(INDIRECT_ADDR), .INDIRECT_WR(INDIRECT_WR), .INDIRECT_RD(INDIRECT_RD),
  .CABLE_TEST_RUN(CABLE_TEST_RUN), .CABLE_TEST_TX_DISABLE(CABLE_TEST_TX_DISABLE),
  .CABLE_TEST_DONE(CABLE_TEST_DONE), .CABLE_HIGH_THRESHOLD(CABLE_HIGH_THRESHOLD),
  .CABLE_LOW_THRESHOLD(CABLE_LOW_THRESHOLD)
);

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic resetn;
  logic [7:0] ev;
  logic [1:0] ab;
  logic [4:0] stat;
  logic [15:0] rx_word;
  logic [1:0] outcome;
  logic [7:0] value;
  logic [3:0] flags;
  logic [15:0] rd;
  logic [15:0] a;
  logic [15:0] last_wdata;
  logic [15:0] last_waddr;
  logic [2:0] tmv;
  logic [1:0] fn;
  logic [37:0] r;
  int n_errors;
  int checked;
  wire mdc;
  wire mdio_line;
  wire mdio_out;
  wire mdio_oe;
  wire [15:0] np_word;
  wire [2:0] tm;
  wire [6:0] ctl;
  wire [4:0] dev;
  wire [15:0] ind_addr;
  wire [15:0] ind_wdata;
  wire [15:0] ind_rdata;
  wire [1:0] ind_st;
  wire run;
  wire [1:0] pair;
  // Rows: write flag, register, write data, expected read.
  localparam logic [37:0] ROWS [0:19] = '{
    {1'b0, 5'h06, 16'h0, 16'h0064}, {1'b0, 5'h07, 16'h0, 16'h2001}, {1'b0, 5'h08, 16'h0, 16'h0000},
    {1'b0, 5'h09, 16'h0, 16'h0200}, {1'b0, 5'h0a, 16'h0, 16'h0000}, {1'b0, 5'h0d, 16'h0, 16'h0000},
    {1'b0, 5'h0e, 16'h0, 16'h0000}, {1'b0, 5'h0f, 16'h0, 16'h2000}, {1'b0, 5'h11, 16'h0, 16'h0000},
    {1'b0, 5'h12, 16'h0, 16'h0000}, {1'b1, 5'h07, 16'hffff, 16'hb7ff}, {1'b1, 5'h11, 16'hffff, 16'h0100},
    {1'b1, 5'h12, 16'h0400, 16'h0440}, {1'b1, 5'h12, 16'h0800, 16'h0bc0}, {1'b1, 5'h12, 16'h0c00, 16'h0c00},
    {1'b1, 5'h0d, 16'hffff, 16'hc01f}, {1'b1, 5'h10, 16'hffff, 16'h0000}, {1'b1, 5'h0f, 16'hffff, 16'h2000},
    {1'b1, 5'h08, 16'hffff, 16'h0000}, {1'b1, 5'h09, 16'h00ff, 16'h0000}
  };
  // A plain pattern keyed on the pointer shows any pointer slip in the read data.
  assign ind_rdata = ind_addr ^ 16'ha5a5;
  pmr_mgmt_regs u_pmr_mgmt_regs (
    .SYS_CLK(clk), .RESETN(resetn), .MDC(mdc), .MDIO_IN(mdio_line), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe),
    .PAR_DET_FAULT(ev[7]), .PARTNER_NP_ABLE(ab[1]), .PARTNER_AN_ABLE(ab[0]), .RX_PAGE_VALID(ev[6]),
    .RX_PAGE_WORD(rx_word), .NP_TX_SENT(ev[4]), .NP_TX_WORD(np_word), .TEST_MODE(tm),
    .MS_MANUAL_EN(ctl[6]), .MS_MANUAL_MASTER(ctl[5]), .MULTI_PORT(ctl[4]), .ADV_1000FD(ctl[3]),
    .ADV_1000HD(ctl[2]), .MS_CONFIG_FAULT(ev[5]), .MS_RESOLVED_MASTER(stat[4]), .LOCAL_RX_OK(stat[3]),
    .REMOTE_RX_OK(stat[2]), .PARTNER_1000FD(stat[1]), .PARTNER_1000HD(stat[0]), .IDLE_ERROR(ev[0]),
    .INDIRECT_DEVICE_SELECT(dev), .INDIRECT_ADDR(ind_addr), .INDIRECT_WDATA(ind_wdata), .INDIRECT_WR(ind_st[1]),
    .INDIRECT_RD(ind_st[0]), .INDIRECT_RDATA(ind_rdata), .REMOTE_LOOPBACK(ctl[1]), .CABLE_TEST_RUN(run),
    .CABLE_TEST_TX_DISABLE(ctl[0]), .CABLE_TEST_PAIR_SELECT(pair), .CABLE_HIGH_THRESHOLD(),
    .CABLE_LOW_THRESHOLD(), .CABLE_TEST_DONE(ev[3]), .CABLE_TEST_OUTCOME(outcome), .CABLE_TEST_VALUE(value),
    .CABLE_FAIL_FLAGS(flags), .CABLE_LOW_PULSE(ev[2]), .CABLE_HIGH_PULSE(ev[1])
  );
  pmr_mdio_station u_pmr_mdio_station (.clk(clk), .dev_out(mdio_out), .dev_oe(mdio_oe), .mdc(mdc), .line(mdio_line));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ind_st[1]) begin
      last_wdata <= ind_wdata;
      last_waddr <= ind_addr;
    end
  end
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [7:0] m);
    tick;
    ev = m;
    tick;
    ev = 8'h00;
  endtask
  task automatic mw(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    u_pmr_mdio_station.frame(2'h1, ra, wd, d);
  endtask
  task automatic mr(input logic [4:0] ra, output logic [15:0] v);
    u_pmr_mdio_station.frame(2'h2, ra, 16'h0, v);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  initial begin
    resetn = 1'b0;
    ev = 8'h00;
    ab = 2'b00;
    stat = 5'h00;
    rx_word = 16'h0;
    outcome = 2'h0;
    value = 8'h0;
    flags = 4'h0;
    repeat (5) tick;
    resetn = 1'b1;
    repeat (4) tick;
    for (int i = 0; i < 20; i++) begin
      r = ROWS[i];
      if (r[37]) mw(r[36:32], r[31:16]);
      mr(r[36:32], rd);
      chk($sformatf("reg %h", r[36:32]), rd, r[15:0]);
    end
    for (int i = 0; i < 8; i++) begin
      tmv = i[2:0];
      mw(5'h09, {tmv, 1'b1, tmv[0], tmv[1], 10'h200});
      mr(5'h09, rd);
      chk("ms ctrl", rd, {tmv, 1'b1, tmv[0], tmv[1], 10'h200});
      chk("test mode", tm, (i < 5) ? tmv : 3'h0);
      chk("manual", ctl[6:4], {1'b1, tmv[0], tmv[1]});
    end
    mw(5'h09, 16'h0a00);
    chk("manual off", ctl, 7'b0001010);
    ab = 2'b11;
    stat = 5'b11010;
    rx_word = 16'hd5a3;
    pulse(8'hf0);
    repeat (300) pulse(8'h01);
    mr(5'h06, rd);
    chk("expansion", rd, 16'h007f);
    mr(5'h06, rd);
    chk("expansion again", rd, 16'h006d);
    mr(5'h08, rd);
    chk("np rx", rd, 16'hd5a3);
    mr(5'h07, rd);
    chk("np tx", rd, 16'hbfff);
    chk("np word", np_word, 16'hbfff);
    mr(5'h0a, rd);
    chk("ms status", rd, 16'he8ff);
    mr(5'h0a, rd);
    chk("ms status again", rd, 16'h6800);
    mw(5'h0d, 16'h0003);
    mw(5'h0e, 16'h0014);
    chk("ind addr", ind_addr, 16'h0014);
    chk("ind dev", dev, 5'h03);
    a = 16'h0014;
    for (int f = 1; f < 4; f++) begin
      fn = f[1:0];
      mw(5'h0d, {fn, 9'h0, 5'h03});
      mw(5'h0e, 16'h1230 + 16'(f));
      chk("ind wdata", last_wdata, 16'h1230 + 16'(f));
      chk("ind waddr", last_waddr, a);
      a = a + ((fn != 2'h1) ? 16'h1 : 16'h0);
      chk("ind addr w", ind_addr, a);
      mr(5'h0e, rd);
      chk("ind rdata", rd, a ^ 16'ha5a5);
      a = a + ((fn == 2'h2) ? 16'h1 : 16'h0);
      chk("ind addr r", ind_addr, a);
    end
    mw(5'h12, 16'hc000);
    chk("held", {run, ctl[0]}, 2'b01);
    outcome = 2'h1;
    pulse(8'h08);
    mr(5'h12, rd);
    chk("held reg", rd, 16'hc000);
    mw(5'h12, 16'h8000);
    chk("run", run, 1'b1);
    mw(5'h12, 16'h0000);
    chk("stopped", run, 1'b0);
    for (int i = 0; i < 4; i++) begin
      fn = i[1:0];
      mw(5'h12, {2'b10, fn, 12'h0});
      chk("pair", {run, pair}, {1'b1, fn});
      repeat (5) pulse(8'h04);
      repeat (2) pulse(8'h02);
      outcome = fn;
      value = 8'h40 | {6'h0, fn};
      flags = 4'ha;
      pulse(8'h08);
      mr(5'h12, rd);
      chk("result", rd, {2'b00, fn, 2'b00, fn, (fn == 2'h3) ? 8'hae : value});
      chk("done", run, 1'b0);
    end
    // A frame for another station address must neither drive the line nor change a register.
    u_pmr_mdio_station.phy = 5'h02;
    mw(5'h11, 16'h0000);
    mr(5'h11, rd);
    chk("other phy", rd, 16'hffff);
    u_pmr_mdio_station.phy = 5'h01;
    mr(5'h11, rd);
    chk("loop kept", rd, 16'h0100);
    resetn = 1'b0;
    repeat (5) tick;
    resetn = 1'b1;
    repeat (4) tick;
    chk("reset ports", {tm, ctl, mdio_oe, ind_st}, {3'h0, 7'b0001000, 3'b000});
    chk("reset np word", np_word, 16'h2001);
    print_verdict;
  end
endmodule // tb_top
